// ==== verilog/rstctl_top.sv ====
// Reset controller: sequencer, reset-pin manager and APB register file.
// Assumes clk is the always-running slow clock and arst_n is power-on reset.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - All resets generated on the slow clock.
// - Processor reset also restarts the watchdog.
// - Peripheral reset covers all peripherals together.
// - Peripheral event, pin low or software reset.
// - Three reset outputs selectable in any combination.
// - Sequencer requests pin assertion from pin manager.
// - Pin held low for programmable stretch time.
// - Mode register survives all generated system resets.
// - Pin sampled each cycle; low reports user reset.
// - User reset enable cleared blocks pin reset.
// - Sampled pin level always readable in status.
// - Seen bit set on pin low; read clears.
// - Interrupt enable turns pin reset into interrupt.
// - Cause of last reset recorded and readable.
// - Pin pulled low only while sequencer requires.
module rstctl_top
  import rstctl_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = HOLD_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Reset events from peripherals
  input  wire logic        wdt_fault,
  // Generated resets, active low
  output logic             proc_rst_n,
  output logic             wdt_rst_n,
  output logic             periph_rst_n,
  // Open-drain reset pin
  input  wire logic        ext_rst_pin_i,
  output logic             ext_rst_pin_o,
  output logic             ext_rst_pin_oe,
  // Interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // Pin synchroniser and filter
  // ----------------------------------------------------------------
  logic [2:0] pin_sync_q;
  logic       pin_lvl_q;
  logic       pin_lvl_d;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_sync_q <= 3'h7;
      pin_lvl_q  <= 1'b1;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], ext_rst_pin_i};
      pin_lvl_q  <= pin_lvl_d;
    end
  end

  // Level changes only once stages two and three agree
  assign pin_lvl_d = (pin_sync_q[1] == pin_sync_q[2]) ? pin_sync_q[2] : pin_lvl_q;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic acc;
  logic wr;
  logic rd;
  logic hit_cmd;
  logic hit_status;
  logic hit_mode;
  logic hit_istat;
  logic hit_imask;
  logic hit_any;
  logic pready_q;

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
    reg_hit = (a == ofs);
  endfunction

  assign acc        = psel & penable & ~pready_q;
  assign wr         = acc & pwrite;
  assign rd         = acc & ~pwrite;
  assign hit_cmd    = reg_hit(paddr, OFS_CMD);
  assign hit_status = reg_hit(paddr, OFS_STATUS);
  assign hit_mode   = reg_hit(paddr, OFS_MODE);
  assign hit_istat  = reg_hit(paddr, OFS_IRQ_STAT);
  assign hit_imask  = reg_hit(paddr, OFS_IRQ_MASK);
  assign hit_any    = hit_cmd | hit_status | hit_mode | hit_istat | hit_imask;

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  // Reset only by power-up; the resets this block generates never touch it
  rstctl_mode_t mode_q;
  rstctl_mode_t mode_d;

  assign mode_d = (wr & hit_mode) ?
                  rstctl_mode_t'{usr_en: pwdata[MD_USR_EN_BIT],
                                 irq_en: pwdata[MD_IRQ_EN_BIT],
                                 len:    pwdata[MD_LEN_LSB +: 4]} : mode_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= '{usr_en: MODE_USR_EN_RST, irq_en: MODE_IRQ_EN_RST, len: MODE_LEN_RST};
    end else begin
      mode_q <= mode_d;
    end
  end

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  rstctl_state_t state_q;
  rstctl_state_t state_d;
  logic          drive_q;
  logic          usr_evt;
  logic          usr_rst;
  logic          usr_irq;
  logic          sw_req;
  rstctl_sel_t   sw_sel;
  logic          pin_fall;
  logic [2:0]    echo_q;
  logic          own_drive;

  // Filter lags the pin by four cycles: mask the echo of our own pulse
  // Limitation: an outside pull starting in that shadow is missed
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      echo_q <= 3'h0;
    end else begin
      echo_q <= {echo_q[1:0], drive_q};
    end
  end

  assign own_drive = drive_q | (|echo_q);
  assign pin_fall  = pin_lvl_q & ~pin_lvl_d;

  // Falling edge of the filtered level; our own drive is not a user reset
  assign usr_evt = pin_fall & ~own_drive;
  assign usr_rst = usr_evt & mode_q.usr_en & ~mode_q.irq_en;
  assign usr_irq = usr_evt & mode_q.irq_en;
  assign sw_sel  = '{proc:   pwdata[CMD_PROC_BIT],
                     periph: pwdata[CMD_PERIPH_BIT],
                     ext:    pwdata[CMD_EXT_BIT]};
  assign sw_req  = wr & hit_cmd & (|sw_sel);

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  rstctl_sel_t          sel_q;
  rstctl_sel_t          sel_d;
  rstctl_cause_t        cause_q;
  rstctl_cause_t        cause_d;
  logic [15:0]          hold_q;
  logic [15:0]          hold_d;
  logic [STRETCH_W-1:0] stretch_q;
  logic [STRETCH_W-1:0] stretch_d;
  logic [STRETCH_W-1:0] stretch_load;
  logic                 start;
  logic                 hold_done;
  logic                 stretch_done;
  logic                 finish;

  // Stretch of 2^(len+1) cycles
  assign stretch_load = STRETCH_W'(1) << (5'(mode_q.len) + 5'd1);
  assign start        = (state_q == SEQ_IDLE) & (wdt_fault | usr_rst | sw_req);
  assign hold_done    = (hold_q == 16'h0000);
  assign stretch_done = (stretch_q == '0);
  // A user reset lasts as long as the pin stays low
  assign finish       = hold_done & stretch_done & pin_lvl_q;

  always_comb begin
    state_d   = state_q;
    sel_d     = sel_q;
    cause_d   = cause_q;
    hold_d    = hold_q;
    stretch_d = stretch_q;
    case (state_q)
      SEQ_IDLE: begin
        if (start) begin
          state_d = SEQ_ACTIVE;
          hold_d  = 16'(HOLD_CYCLES - 1);
          // Watchdog wins over pin, pin over software
          if (wdt_fault) begin
            sel_d   = '{proc: 1'b1, periph: 1'b1, ext: 1'b0};
            cause_d = RST_WATCHDOG;
          end else if (usr_rst) begin
            sel_d   = '{proc: 1'b1, periph: 1'b1, ext: 1'b0};
            cause_d = RST_USER;
          end else begin
            sel_d   = sw_sel;
            cause_d = RST_SOFTWARE;
          end
          stretch_d = sel_d.ext ? stretch_load : '0;
        end
      end
      SEQ_ACTIVE: begin
        if (!hold_done) begin
          hold_d = hold_q - 16'h0001;
        end
        if (!stretch_done) begin
          stretch_d = stretch_q - STRETCH_W'(1);
        end
        if (finish) begin
          state_d = SEQ_IDLE;
          sel_d   = '{proc: 1'b0, periph: 1'b0, ext: 1'b0};
        end
      end
      default: begin
        state_d = SEQ_IDLE;
        sel_d   = '{proc: 1'b0, periph: 1'b0, ext: 1'b0};
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q   <= SEQ_IDLE;
      sel_q     <= '{proc: 1'b0, periph: 1'b0, ext: 1'b0};
      cause_q   <= RST_POWER_UP;
      hold_q    <= 16'h0000;
      stretch_q <= '0;
    end else begin
      state_q   <= state_d;
      sel_q     <= sel_d;
      cause_q   <= cause_d;
      hold_q    <= hold_d;
      stretch_q <= stretch_d;
    end
  end

  // ----------------------------------------------------------------
  // Reset outputs
  // ----------------------------------------------------------------
  logic proc_rst_n_q;
  logic periph_rst_n_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      proc_rst_n_q   <= 1'b0;
      periph_rst_n_q <= 1'b0;
    end else begin
      proc_rst_n_q   <= ~sel_d.proc;
      periph_rst_n_q <= ~sel_d.periph;
    end
  end

  // ----------------------------------------------------------------
  // Pin manager drive
  // ----------------------------------------------------------------
  // Released the cycle the stretch count runs out
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= sel_d.ext & (stretch_d != '0);
    end
  end

  assign proc_rst_n     = proc_rst_n_q;
  // Watchdog shares the processor reset flop so both restart together
  assign wdt_rst_n      = proc_rst_n_q;
  assign periph_rst_n   = periph_rst_n_q;
  // Open drain: only ever pulls low
  assign ext_rst_pin_o  = 1'b0;
  assign ext_rst_pin_oe = drive_q;

  // ----------------------------------------------------------------
  // Status and interrupts
  // ----------------------------------------------------------------
  logic              seen_q;
  logic              seen_d;
  logic [IRQ_W-1:0]  istat_q;
  logic [IRQ_W-1:0]  istat_d;
  logic [IRQ_W-1:0]  imask_q;
  logic [IRQ_W-1:0]  ievt;
  logic              irq_q;
  logic [IRQ_W-1:0]  imask_d;
  logic              irq_d;
  logic              done_evt;

  assign done_evt = (state_q == SEQ_ACTIVE) & finish;
  assign ievt     = {done_evt, usr_irq};
  // Set wins over the clear-on-read
  assign seen_d   = pin_fall | (seen_q & ~(rd & hit_status));
  // Set wins over write-one-to-clear
  assign istat_d  = ievt | (istat_q & ~((wr & hit_istat) ? pwdata[IRQ_W-1:0] : '0));
  assign imask_d  = (wr & hit_imask) ? pwdata[IRQ_W-1:0] : imask_q;
  assign irq_d    = |(istat_d & imask_d);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seen_q  <= 1'b0;
      istat_q <= '0;
    end else begin
      seen_q  <= seen_d;
      istat_q <= istat_d;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      imask_q <= '0;
      irq_q   <= 1'b0;
    end else begin
      imask_q <= imask_d;
      irq_q   <= irq_d;
    end
  end

  assign irq = irq_q;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [31:0] rdata;
  logic [31:0] status_word;
  logic [31:0] mode_word;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_SEEN_BIT]            = seen_q;
    status_word[ST_BUSY_BIT]            = (state_q == SEQ_ACTIVE);
    status_word[ST_TYPE_LSB +: 2]       = cause_q;
    status_word[ST_LEVEL_BIT]           = pin_lvl_q;
    mode_word = 32'h0000_0000;
    mode_word[MD_USR_EN_BIT]            = mode_q.usr_en;
    mode_word[MD_IRQ_EN_BIT]            = mode_q.irq_en;
    mode_word[MD_LEN_LSB +: 4]          = mode_q.len;
  end

  assign rdata = hit_status ? status_word :
                 hit_mode   ? mode_word :
                 hit_istat  ? {{(32-IRQ_W){1'b0}}, istat_q} :
                 hit_imask  ? {{(32-IRQ_W){1'b0}}, imask_q} : 32'h0000_0000;

  logic [31:0] prdata_q;
  logic        pslverr_q;

  // One wait state: answer in the second access cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= acc;
      prdata_q  <= rd ? rdata : 32'h0000_0000;
      pslverr_q <= acc & ~hit_any;
    end
  end

  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

endmodule // rstctl_top

`default_nettype wire

// ==== verilog/rstctl_pkg.sv ====
// Shared constants and types for the reset controller.
// Assumes one 25 MHz always-running slow clock and an APB register port.
package rstctl_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 25000000;
  localparam int unsigned HOLD_NS      = 120;
  // Least time, rounded up to whole cycles
  localparam int unsigned HOLD_CYC     = (HOLD_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned STRETCH_W    = 17;

  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CMD      = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_MODE     = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

  // Command bits
  localparam int unsigned CMD_PROC_BIT   = 0;
  localparam int unsigned CMD_PERIPH_BIT = 1;
  localparam int unsigned CMD_EXT_BIT    = 2;

  // Status fields
  localparam int unsigned ST_SEEN_BIT  = 0;
  localparam int unsigned ST_BUSY_BIT  = 1;
  localparam int unsigned ST_TYPE_LSB  = 8;
  localparam int unsigned ST_LEVEL_BIT = 16;

  // Mode fields
  localparam int unsigned MD_USR_EN_BIT = 0;
  localparam int unsigned MD_IRQ_EN_BIT = 4;
  localparam int unsigned MD_LEN_LSB    = 8;

  // Interrupt status bits
  localparam int unsigned IRQ_USER_BIT = 0;
  localparam int unsigned IRQ_DONE_BIT = 1;
  localparam int unsigned IRQ_W        = 2;

  // Reset values
  localparam logic       MODE_USR_EN_RST = 1'b1;
  localparam logic       MODE_IRQ_EN_RST = 1'b0;
  localparam logic [3:0] MODE_LEN_RST    = 4'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RST_POWER_UP = 2'b00,
    RST_WATCHDOG = 2'b01,
    RST_SOFTWARE = 2'b10,
    RST_USER     = 2'b11
  } rstctl_cause_t;

  typedef enum logic {
    SEQ_IDLE   = 1'b0,
    SEQ_ACTIVE = 1'b1
  } rstctl_state_t;

  typedef struct packed {
    logic       usr_en;
    logic       irq_en;
    logic [3:0] len;
  } rstctl_mode_t;

  typedef struct packed {
    logic proc;
    logic periph;
    logic ext;
  } rstctl_sel_t;

endpackage

// ==== verification/rstctl_checker.sv ====
// Port checker for rstctl_top, bound into every instance.
// Assumes clk rising edge and arst_n asynchronous, active low.
`timescale 1ns/10ps
`default_nettype none
module rstctl_checker
  import rstctl_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = HOLD_CYC
) (
  // Clock, reset and bus
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Resets, pin and interrupt
  input wire logic        wdt_fault,
  input wire logic        proc_rst_n,
  input wire logic        wdt_rst_n,
  input wire logic        periph_rst_n,
  input wire logic        ext_rst_pin_i,
  input wire logic        ext_rst_pin_o,
  input wire logic        ext_rst_pin_oe,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Cycles with all resets and the pin idle; no sequence outlasts this
  localparam int unsigned QUIET_MIN = HOLD_CYCLES + 8;
  logic [7:0] quiet_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      quiet_q <= 8'h00;
    end else if (!proc_rst_n || !periph_rst_n || ext_rst_pin_oe || !ext_rst_pin_i) begin
      quiet_q <= 8'h00;
    end else if (quiet_q != 8'hFF) begin
      quiet_q <= quiet_q + 8'h01;
    end
  end

  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside answer cycle");
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  a_wdt_same_proc: assert property (wdt_rst_n == proc_rst_n)
    else $error("watchdog reset differs from processor reset");
  a_pin_drive_low: assert property (ext_rst_pin_o == 1'b0)
    else $error("reset pin driven high");
  a_stretch_min: assert property ($rose(ext_rst_pin_oe) |-> ext_rst_pin_oe [*2])
    else $error("pin drive shorter than two cycles");
  a_wdt_trig_reset: assert property (wdt_fault && proc_rst_n && periph_rst_n && !ext_rst_pin_oe
    && 32'(quiet_q) >= QUIET_MIN |=> !proc_rst_n && !periph_rst_n && !ext_rst_pin_oe)
    else $error("watchdog event did not reset processor and peripherals");
  a_release_together: assert property ($rose(proc_rst_n) |-> periph_rst_n && !ext_rst_pin_oe)
    else $error("resets not released together");

  c_user_reset: cover property ($fell(proc_rst_n) && !ext_rst_pin_i);
  c_stretch: cover property ($fell(ext_rst_pin_oe));
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (pslverr);
endmodule // rstctl_checker

bind rstctl_top rstctl_checker #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (
  .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .wdt_fault(wdt_fault), .proc_rst_n(proc_rst_n), .wdt_rst_n(wdt_rst_n),
  .periph_rst_n(periph_rst_n), .ext_rst_pin_i(ext_rst_pin_i), .ext_rst_pin_o(ext_rst_pin_o),
  .ext_rst_pin_oe(ext_rst_pin_oe), .irq(irq)
);
`default_nettype wire

// ==== verification/rstctl_pin_dev.sv ====
// Outside device sharing the open-drain reset pin.
// Assumes the bench resolves the wire with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module rstctl_pin_dev (
  // Clock and command
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [7:0] len,
  // High while pulling the pin low
  output logic            pull_low
);
  logic [7:0] cnt_q = 8'h00;

  // Only pulls low or lets go, never for less than a cycle
  always @(posedge clk) begin
    if (go)
      cnt_q <= len;
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end
  assign pull_low = (cnt_q != 8'h00);
endmodule // rstctl_pin_dev
`default_nettype wire

// ==== verification/rstctl_bench.sv ====
// Self-checking bench for rstctl_top with an outside pin device.
// Assumes a pull-up on the reset pin; HOLD_CYCLES shortened to 1.
`timescale 1ns/10ps
`default_nettype none
module rstctl_bench;
  import rstctl_pkg::*;
  typedef struct packed {
    logic        wr;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] exp;
    logic        err;
  } rstctl_row_t;
  localparam rstctl_row_t ROWS [11] = '{
    '{1'b0, OFS_MODE, 32'h0, 32'h1, 1'b0}, '{1'b1, OFS_MODE, 32'hF11, 32'h0, 1'b0},
    '{1'b0, OFS_MODE, 32'h0, 32'hF11, 1'b0}, '{1'b1, OFS_MODE, 32'h1, 32'h0, 1'b0},
    '{1'b0, OFS_CMD, 32'h0, 32'h0, 1'b0}, '{1'b0, OFS_IRQ_MASK, 32'h0, 32'h0, 1'b0},
    '{1'b1, OFS_IRQ_MASK, 32'h3, 32'h0, 1'b0}, '{1'b0, OFS_IRQ_MASK, 32'h0, 32'h3, 1'b0},
    '{1'b1, OFS_IRQ_MASK, 32'h2, 32'h0, 1'b0}, '{1'b0, 8'h14, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'h14, 32'h5, 32'h0, 1'b1}};
  logic        clk, arst_n, psel, penable, pwrite, wdt_fault, dev_go, err, dev_low;
  logic        pready, pslverr, proc_rst_n, wdt_rst_n, periph_rst_n, ext_rst_pin_o, ext_rst_pin_oe, irq;
  logic [7:0]  paddr, dev_len;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  sel;
  int          n_fail, num_checks, oe_run, oe_last, n_low, n0;
  // Pull-up: released wire reads high
  wire logic   pin_lvl = ~((ext_rst_pin_oe & ~ext_rst_pin_o) | dev_low);

  rstctl_top #(.HOLD_CYCLES(1)) dut_u (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wdt_fault(wdt_fault),
    .proc_rst_n(proc_rst_n), .wdt_rst_n(wdt_rst_n), .periph_rst_n(periph_rst_n),
    .ext_rst_pin_i(pin_lvl), .ext_rst_pin_o(ext_rst_pin_o), .ext_rst_pin_oe(ext_rst_pin_oe), .irq(irq));
  rstctl_pin_dev dev_u (.clk(clk), .go(dev_go), .len(dev_len), .pull_low(dev_low));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Length of the last pin drive and count of processor-reset cycles
  always @(posedge clk) begin
    if (ext_rst_pin_oe === 1'b1)
      oe_run <= oe_run + 1;
    else if (oe_run != 0) begin
      oe_last <= oe_run;
      oe_run <= 0;
    end
    if (proc_rst_n === 1'b0)
      n_low <= n_low + 1;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle();
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
    end while (rd[ST_BUSY_BIT] !== 1'b0);
  endtask
  task automatic pull(input logic [7:0] len);
    dev_len <= len;
    dev_go <= 1'b1;
    @(posedge clk);
    dev_go <= 1'b0;
    repeat (20) @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end

  initial begin
    {arst_n, psel, penable, pwrite, wdt_fault, dev_go, paddr, dev_len, pwdata} = '0;
    {n_fail, num_checks, oe_run, oe_last, n_low} = '0;
    repeat (5) @(posedge clk);
    chk({proc_rst_n, periph_rst_n, ext_rst_pin_oe, irq, pready}, 5'h00);
    arst_n <= 1'b1;
    $display("reset test done");
    foreach (ROWS[i]) begin
      apb(ROWS[i].wr, ROWS[i].a, ROWS[i].d);
      chk(rd, ROWS[i].exp);
      chk(err, ROWS[i].err);
    end
    $display("register table done");
    // Every output combination, then a long pin stretch
    for (int s = 1; s < 9; s++) begin
      if (s == 8) apb(1'b1, OFS_MODE, 32'h301);
      sel = (s == 8) ? 3'h4 : 3'(s);
      apb(1'b1, OFS_CMD, {29'h0, sel});
      chk({proc_rst_n, periph_rst_n, ext_rst_pin_oe}, {~sel[0], ~sel[1], sel[2]});
      chk(wdt_rst_n, proc_rst_n);
      wait_idle();
      chk(rd[9:8], RST_SOFTWARE);
      if (sel[2]) chk(oe_last, (s == 8) ? 16 : 2);
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      chk({rd[IRQ_DONE_BIT], irq}, 2'b11);
      apb(1'b1, OFS_IRQ_STAT, 32'h2);
      apb(1'b0, OFS_MODE, 32'h0);
      chk(irq, 1'b0);
      chk(rd, (s == 8) ? 32'h301 : 32'h1);
    end
    $display("software reset test done");
    wdt_fault <= 1'b1;
    @(posedge clk);
    wdt_fault <= 1'b0;
    @(posedge clk);
    chk({proc_rst_n, wdt_rst_n, periph_rst_n, ext_rst_pin_oe}, 4'h0);
    wait_idle();
    chk(rd[9:8], RST_WATCHDOG);
    $display("watchdog test done");
    dev_len <= 8'd30;
    dev_go <= 1'b1;
    @(posedge clk);
    dev_go <= 1'b0;
    repeat (8) @(posedge clk);
    chk(proc_rst_n, 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({rd[ST_LEVEL_BIT], rd[ST_SEEN_BIT]}, 2'b01);
    wait_idle();
    chk({rd[ST_LEVEL_BIT], rd[9:8], rd[ST_SEEN_BIT]}, {1'b1, RST_USER, 1'b0});
    $display("user reset test done");
    apb(1'b1, OFS_MODE, 32'h0);
    n0 = n_low;
    pull(8'd10);
    chk(n_low - n0, 0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[ST_SEEN_BIT], 1'b1);
    apb(1'b1, OFS_MODE, 32'h11);
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    n0 = n_low;
    pull(8'd10);
    chk(n_low - n0, 0);
    chk(irq, 1'b1);
    apb(1'b1, OFS_IRQ_STAT, 32'h1);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk({rd[IRQ_USER_BIT], irq}, 2'b00);
    $display("pin disable and interrupt test done");
    print_verdict();
  end
endmodule // rstctl_bench
`default_nettype wire
